// file: dv/aar_partner_model.sv
/* Remote transceiver model: sends link code words one per cycle.
   Assumes the caller enters a task just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module aar_partner_model (
  input wire logic sys_clk,
  output logic [15:0] rx_word,
  output logic rx_word_valid
);
  initial
  begin
    rx_word = 16'h0000;
    rx_word_valid = 1'b0;
  end
  task send(input logic [15:0] w);
    @(posedge sys_clk);
    rx_word <= w;
    rx_word_valid <= 1'b1;
  endtask
  // Released line shows the inverse so a stale word can never match
  task release_line;
    @(posedge sys_clk);
    rx_word <= ~rx_word;
    rx_word_valid <= 1'b0;
  endtask
  // Three back-to-back words, the last may carry the acknowledge
  task page(input logic [15:0] w, input logic [15:0] last);
    send(w);
    send(w);
    send(last);
    release_line;
  endtask
endmodule
`default_nettype wire

// file: dv/aar_regs_properties.sv
/* Port checker for the ability register bank, bound to aar_regs.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module aar_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic strap_no_ten_full,
  input wire logic strap_no_ten_half,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic an_restart,
  input wire logic local_more_pages,
  input wire logic [15:0] adv_word,
  input wire logic [15:0] partner_word,
  input wire logic [5:0] flags,
  input wire logic base_page_done,
  input wire logic next_page_active,
  input wire logic exchange_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Acknowledge masked as in the matching; the third word, ack and all, is kept
  sequence s_same;
    rx_word_valid && !an_restart && (rx_word & 16'hbfff) == ($past(rx_word) & 16'hbfff);
  endsequence
  sequence s_three;
    !base_page_done && rx_word_valid && !an_restart ##1 s_same ##1 s_same ##1 !an_restart;
  endsequence
  property p_load;
    s_three |=> partner_word == $past(rx_word, 2);
  endproperty
  a_load: assert property (p_load) else $error("partner word not loaded");
  property p_phase;
    $rose(base_page_done) |-> next_page_active == (partner_word[15] | $past(local_more_pages))
      && exchange_done == !(partner_word[15] | $past(local_more_pages));
  endproperty
  a_phase: assert property (p_phase) else $error("wrong phase after base page");
  property p_rst;
    $fell(sys_rst) |-> partner_word == 16'h0000 && adv_word == {9'h000,
      ~$past(strap_no_ten_full), ~$past(strap_no_ten_half), 5'h01};
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset values");
  property p_wr;
    reg_wr && reg_addr == 5'h04 |=> adv_word == {9'h000, $past(reg_wdata[6:5]), 5'h01};
  endproperty
  a_wr: assert property (p_wr) else $error("offer bits not written");
  property p_rd_part;
    reg_rd && reg_addr == 5'h05 |=> reg_rdata == $past(partner_word);
  endproperty
  a_rd_part: assert property (p_rd_part) else $error("partner read wrong");
  property p_rd_adv;
    reg_rd && reg_addr == 5'h04 |=> reg_rdata == $past(adv_word);
  endproperty
  a_rd_adv: assert property (p_rd_adv) else $error("offer read wrong");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_flags;
    flags == partner_word[15:10];
  endproperty
  a_flags: assert property (p_flags) else $error("partner flags differ");
  property p_sel;
    adv_word[4:0] == 5'h01;
  endproperty
  a_sel: assert property (p_sel) else $error("selector not one");
endmodule
bind aar_regs aar_props u_aar_props (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .strap_no_ten_full, .strap_no_ten_half, .rx_word, .rx_word_valid,
  .an_restart, .local_more_pages, .adv_word, .partner_word, .base_page_done,
  .next_page_active, .exchange_done, .flags({partner_more_pages, partner_acknowledge,
  partner_remote_fault, partner_extended_pages, partner_asym_pause, partner_sym_pause}));
`default_nettype wire

// file: dv/tb_autoneg_ability_registers.sv
/* Self-checking bench for aar_regs: register access, straps, base and
   next page exchange. Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_ability_registers;
  logic sys_clk, sys_rst, reg_wr, reg_rd, strap_no_ten_full, strap_no_ten_half;
  logic an_restart, local_more_pages, rx_word_valid, base_page_done;
  logic next_page_active, exchange_done;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_word, adv_word, partner_word;
  logic [5:0] flags;
  int err_count = 0;
  int checked = 0;
  aar_regs u_aar_regs (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .strap_no_ten_full, .strap_no_ten_half, .rx_word, .rx_word_valid,
    .an_restart, .local_more_pages, .adv_word, .partner_word,
    .partner_more_pages(flags[5]), .partner_acknowledge(flags[4]),
    .partner_remote_fault(flags[3]), .partner_extended_pages(flags[2]),
    .partner_asym_pause(flags[1]), .partner_sym_pause(flags[0]), .base_page_done,
    .next_page_active, .exchange_done);
  aar_partner_model u_aar_partner_model (.sys_clk, .rx_word, .rx_word_valid);
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic reset(input logic no_full, input logic no_half);
    @(posedge sys_clk);
    strap_no_ten_full <= no_full;
    strap_no_ten_half <= no_half;
    sys_rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask
  task automatic results;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    #50000;
    err_count++;
    results;
  end
  initial
  begin
    {sys_rst, reg_wr, reg_rd, an_restart, local_more_pages} = 5'h10;
    {strap_no_ten_full, strap_no_ten_half} = 2'h0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reset(1'b0, 1'b1);
    rd(5'h04, 16'h0041);
    reset(1'b0, 1'b0);
    rd(5'h04, 16'h0061);
    rd(5'h05, 16'h0000);
    wr(5'h04, 16'h0000);
    rd(5'h04, 16'h0001);
    wr(5'h04, 16'hffbe);
    rd(5'h04, 16'h0021);
    wr(5'h05, 16'hffff);
    rd(5'h05, 16'h0000);
    rd(5'h1f, 16'h0000);
    u_aar_partner_model.page(16'h8de1, 16'hcde1);
    repeat (3) @(posedge sys_clk);
    rd(5'h05, 16'hcde1);
    chk({10'h000, flags}, 16'h0033);
    chk({13'h0000, base_page_done, next_page_active, exchange_done}, 16'h0006);
    u_aar_partner_model.page(16'h0001, 16'h0001);
    repeat (3) @(posedge sys_clk);
    rd(5'h05, 16'hcde1);
    rd(5'h10, 16'h0005);
    @(posedge sys_clk);
    an_restart <= 1'b1;
    @(posedge sys_clk);
    an_restart <= 1'b0;
    u_aar_partner_model.page(16'h3261, 16'h3261);
    repeat (3) @(posedge sys_clk);
    rd(5'h05, 16'h3261);
    rd(5'h10, 16'h0005);
    chk({10'h000, flags}, 16'h000c);
    // Local side holds more pages, so a base page without bit 15 still opens the next phase
    @(posedge sys_clk);
    an_restart <= 1'b1;
    local_more_pages <= 1'b1;
    @(posedge sys_clk);
    an_restart <= 1'b0;
    u_aar_partner_model.page(16'h0021, 16'h4021);
    repeat (3) @(posedge sys_clk);
    rd(5'h05, 16'h4021);
    rd(5'h10, 16'h0003);
    @(posedge sys_clk);
    local_more_pages <= 1'b0;
    u_aar_partner_model.page(16'h0002, 16'h0002);
    repeat (3) @(posedge sys_clk);
    rd(5'h10, 16'h0005);
    results;
  end
endmodule
`default_nettype wire

// file: verilog/aar_page_if.sv
/*
  Carrier for validated link code words from the word checker to the
  register bank. Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface aar_page_if;
  logic [15:0] word;
  logic valid;
  modport src (output word, output valid);
  modport dst (input word, input valid);
endinterface

`default_nettype wire

// file: verilog/aar_pkg.sv
/*
  Constants for the autonegotiation ability register bank: register
  offsets, bit positions, reset values and the link code word match count.
  Assumes a 5-bit management register address and 16-bit register data.
*/
`default_nettype none

package aar_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // ----------------------------------------------------------------
  // Field positions in a link code word
  // ----------------------------------------------------------------
  localparam int BIT_MORE_PAGES = 15;
  localparam int BIT_ACK = 14;
  localparam int BIT_REMOTE_FAULT = 13;
  localparam int BIT_EXT_PAGES = 12;
  localparam int BIT_ASYM_PAUSE = 11;
  localparam int BIT_SYM_PAUSE = 10;
  localparam int BIT_T4 = 9;
  localparam int BIT_HUNDRED_FULL = 8;
  localparam int BIT_HUNDRED_HALF = 7;
  localparam int BIT_TEN_FULL = 6;
  localparam int BIT_TEN_HALF = 5;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;

  // Status register bits
  localparam int STAT_BASE_SEEN = 0;
  localparam int STAT_NEXT_ACTIVE = 1;
  localparam int STAT_DONE = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic OFFER_TEN_FULL_RST = 1'h1;
  localparam logic OFFER_TEN_HALF_RST = 1'h1;
  localparam logic [4:0] SELECTOR_IEEE = 5'h01;
  localparam logic [15:0] PARTNER_RST = 16'h0000;
  localparam logic [15:0] ACK_MASK = 16'hbfff;
  localparam logic [1:0] MATCH_COUNT = 2'h3;

  typedef enum logic [1:0] {AAR_IDLE, AAR_NEXT, AAR_DONE} aar_phase_e;

endpackage

`default_nettype wire

// file: verilog/aar_regs.sv
/*
  Autonegotiation ability register bank: the lower local advertisement
  bits, the partner base page ability register and an exchange status
  register, plus the base and next page phase tracking.
  Assumes the management port follows the plain strobe protocol and the
  receive path strobes each decoded link code word for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none


module aar_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic strap_no_ten_full,
  input wire logic strap_no_ten_half,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic an_restart,
  input wire logic local_more_pages,
  output logic [15:0] adv_word,
  output logic [15:0] partner_word,
  output logic partner_more_pages,
  output logic partner_acknowledge,
  output logic partner_remote_fault,
  output logic partner_extended_pages,
  output logic partner_asym_pause,
  output logic partner_sym_pause,
  output logic base_page_done,
  output logic next_page_active,
  output logic exchange_done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic offer_ten_full;
    logic offer_ten_half;
    logic [15:0] partner;
    aar_pkg::aar_phase_e phase;
    logic base_seen;
    logic [15:0] rdata;
  } aar_state_s;

  aar_state_s q;
  aar_state_s d;

  aar_page_if page ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Local base page as sent and as read back; the upper bits are held
  // elsewhere and read as zero here
  function automatic logic [15:0] adv_image(input logic full, input logic half);
    logic [15:0] w;
    w = 16'h0000;
    w[aar_pkg::BIT_TEN_FULL] = full;
    w[aar_pkg::BIT_TEN_HALF] = half;
    w[aar_pkg::SEL_MSB:aar_pkg::SEL_LSB] = aar_pkg::SELECTOR_IEEE;
    return w;
  endfunction

  function automatic logic [15:0] status_image(input aar_state_s s);
    logic [15:0] w;
    w = 16'h0000;
    w[aar_pkg::STAT_BASE_SEEN] = s.base_seen;
    w[aar_pkg::STAT_NEXT_ACTIVE] = (s.phase == aar_pkg::AAR_NEXT);
    w[aar_pkg::STAT_DONE] = (s.phase == aar_pkg::AAR_DONE);
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Word checker
  // ----------------------------------------------------------------
  aar_word_checker u_checker (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(an_restart),
    .rx_word(rx_word),
    .rx_word_valid(rx_word_valid),
    .page(page.src)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.rdata = 16'h0000;
    if (sys_rst)
    begin
      // Straps are sampled on every reset cycle, so the value present
      // at release is the one kept
      d.offer_ten_full = aar_pkg::OFFER_TEN_FULL_RST ^ strap_no_ten_full;
      d.offer_ten_half = aar_pkg::OFFER_TEN_HALF_RST ^ strap_no_ten_half;
      d.partner = aar_pkg::PARTNER_RST;
      d.phase = aar_pkg::AAR_IDLE;
      d.base_seen = 1'b0;
    end
    else
    begin
      // Register writes; selector and partner are not writable
      if (reg_wr)
      begin
        if (reg_addr == aar_pkg::REG_ADV)
        begin
          d.offer_ten_full = reg_wdata[aar_pkg::BIT_TEN_FULL];
          d.offer_ten_half = reg_wdata[aar_pkg::BIT_TEN_HALF];
        end
      end

      // Read data stand in the following cycle only
      if (reg_rd)
      begin
        if (reg_addr == aar_pkg::REG_ADV)
        begin
          d.rdata = adv_image(q.offer_ten_full, q.offer_ten_half);
        end
        else if (reg_addr == aar_pkg::REG_PARTNER)
        begin
          d.rdata = q.partner;
        end
        else if (reg_addr == aar_pkg::REG_STATUS)
        begin
          d.rdata = status_image(q);
        end
        else
        begin
          d.rdata = 16'h0000;
        end
      end

      // Exchange phases
      if (an_restart)
      begin
        // Partner data stays visible across a restart; only reset clears it
        d.phase = aar_pkg::AAR_IDLE;
        d.base_seen = 1'b0;
      end
      else if (page.valid)
      begin
        case (q.phase)
          aar_pkg::AAR_IDLE:
          begin
            d.partner = page.word;
            d.base_seen = 1'b1;
            if (page.word[aar_pkg::BIT_MORE_PAGES] || local_more_pages)
            begin
              d.phase = aar_pkg::AAR_NEXT;
            end
            else
            begin
              d.phase = aar_pkg::AAR_DONE;
            end
          end
          aar_pkg::AAR_NEXT:
          begin
            // Next pages do not touch the base page image
            if (!page.word[aar_pkg::BIT_MORE_PAGES] && !local_more_pages)
            begin
              d.phase = aar_pkg::AAR_DONE;
            end
          end
          aar_pkg::AAR_DONE:
          begin
            d.phase = aar_pkg::AAR_DONE;
          end
          default:
          begin
            d.phase = aar_pkg::AAR_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = q.rdata;
  assign adv_word = adv_image(q.offer_ten_full, q.offer_ten_half);
  assign partner_word = q.partner;
  assign partner_more_pages = q.partner[aar_pkg::BIT_MORE_PAGES];
  // Only an internal handshake view; nothing here acts on it
  assign partner_acknowledge = q.partner[aar_pkg::BIT_ACK];
  assign partner_remote_fault = q.partner[aar_pkg::BIT_REMOTE_FAULT];
  assign partner_extended_pages = q.partner[aar_pkg::BIT_EXT_PAGES];
  assign partner_asym_pause = q.partner[aar_pkg::BIT_ASYM_PAUSE];
  assign partner_sym_pause = q.partner[aar_pkg::BIT_SYM_PAUSE];
  assign base_page_done = q.base_seen;
  assign next_page_active = (q.phase == aar_pkg::AAR_NEXT);
  assign exchange_done = (q.phase == aar_pkg::AAR_DONE);

endmodule

`default_nettype wire

// file: verilog/aar_word_checker.sv
/*
  Link code word checker: passes on a received word once it has been
  seen the match count of times in a row, the acknowledge bit ignored.
  Assumes the receiver strobes each decoded word for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module aar_word_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  aar_page_if.src page
);

  typedef struct packed {
    logic [15:0] last;
    logic [1:0] hits;
    logic [15:0] word;
    logic valid;
  } aar_chk_s;

  aar_chk_s q;
  aar_chk_s d;
  logic same;

  // Acknowledge toggles during the exchange, so it must not break a match
  assign same = ((rx_word ^ q.last) & aar_pkg::ACK_MASK) == 16'h0000;

  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    if (sys_rst || restart)
    begin
      d = '0;
    end
    else if (rx_word_valid)
    begin
      if (same && (q.hits != 2'h0))
      begin
        // Saturate so a steady word is passed on once only
        if (q.hits != aar_pkg::MATCH_COUNT)
        begin
          d.hits = 2'(q.hits + 2'h1);
          if (2'(q.hits + 2'h1) == aar_pkg::MATCH_COUNT)
          begin
            d.word = rx_word;
            d.valid = 1'b1;
          end
        end
        d.last = rx_word;
      end
      else
      begin
        d.last = rx_word;
        d.hits = 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    q <= d;
  end

  assign page.word = q.word;
  assign page.valid = q.valid;

endmodule

`default_nettype wire
